// ==== common/acs_pkg.sv ====
// package: constants, types and helpers for the command list sequencer
package acs_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int RES_W = 12;
   localparam int IDX_W = 6;
   localparam int OFF_W = 7;
   localparam int SMP_W = 8;
   localparam int LIST_LEN = 64;
   localparam int PUMP_CYC = 2;
   localparam int BUF_CYC = 2;
   localparam int ENTRY_SHIFT = 2;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_CBP = 8'h08;
   localparam logic [7:0] OFS_OFF0 = 8'h0C;
   localparam logic [7:0] OFS_OFF1 = 8'h10;
   localparam logic [7:0] OFS_IDX = 8'h14;
   localparam logic [7:0] OFS_CMD = 8'h18;
   localparam logic [7:0] OFS_RES = 8'h1C;
   // control register bits
   localparam int CTL_EN = 0;
   localparam int CTL_BMOD = 1;
   localparam int CTL_TRIGGER_BIT = 2;
   localparam int CTL_RESTART_BIT = 3;
   localparam int CTL_LOAD_OK_BIT = 4;
   localparam int CTL_IEN = 5;
   // status register bits
   localparam int STA_SEL = 0;
   localparam int STA_IA = 1;
   localparam int STA_IDLE = 2;
   localparam int STA_RDY = 3;
   // command fields
   localparam int CMD_TYP_LSB = 0;
   localparam int CMD_RES_LSB = 2;
   localparam int CMD_SMP_LSB = 4;
   localparam logic [DATA_W-1:0] CMD_RST = 32'h0000_0002;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      TYP_NORMAL = 2'h0,
      TYP_END_SEQ = 2'h1,
      TYP_END_LIST = 2'h2,
      TYP_SPARE = 2'h3
   } acs_cmd_type_t;
   localparam logic [1:0] RES_8 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PUMP = 3'h1,
      ST_SBUF = 3'h3,
      ST_SFIN = 3'h2,
      ST_CONV = 3'h6,
      ST_NEXT = 3'h7
   } acs_state_t;
   typedef struct packed {
      logic req;
      logic [ADDR_W-1:0] addr;
   } acs_mreq_t;
   typedef struct packed {
      logic pump;
      logic buf_conn;
      logic dir_conn;
      logic hold;
      logic [RES_W-1:0] dac;
   } acs_ana_t;
   function automatic acs_cmd_type_t acs_cmd_type(input logic [DATA_W-1:0] cmd);
      return acs_cmd_type_t'(cmd[CMD_TYP_LSB +: 2]);
   endfunction : acs_cmd_type
   function automatic logic [3:0] acs_res_msb(input logic [1:0] r);
      case (r)
         RES_8: return 4'h7;
         RES_10: return 4'h9;
         default: return 4'hB;
      endcase
   endfunction : acs_res_msb
endpackage : acs_pkg

// ==== src/acs_div.sv ====
// converter clock enable divider
`timescale 1ns/1ps
module acs_div #(
   parameter int DIV = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // enable pulse
   output logic tick
);
   logic [7:0] cnt_q;
   wire last = (cnt_q == 8'(DIV - 1));
   always_ff @(posedge clk) begin
      if (rst || last) cnt_q <= 8'h00;
      else cnt_q <= cnt_q + 8'h01;
   end
   assign tick = last;
endmodule : acs_div

// ==== src/acs_sar.sv ====
// successive approximation search engine
`timescale 1ns/1ps
module acs_sar #(
   parameter int W = acs_pkg::RES_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic step,
   input wire logic start,
   input wire logic [1:0] res,
   input wire logic comp,
   // results
   output logic [W-1:0] dac,
   output logic [W-1:0] code,
   output logic done
);
   logic [W-1:0] code_q;
   logic [W-1:0] mask_q;
   logic done_q;
   wire busy = |mask_q;
   wire [W-1:0] keep = comp ? (code_q | mask_q) : code_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         code_q <= '0;
         mask_q <= '0;
         done_q <= 1'b0;
      end else if (start) begin
         code_q <= '0;
         mask_q <= W'(1) << acs_pkg::acs_res_msb(res);
         done_q <= 1'b0;
      end else begin
         done_q <= step && busy && mask_q[0];
         if (step && busy) begin
            code_q <= keep;
            mask_q <= mask_q >> 1;
         end
      end
   end
   assign dac = code_q | mask_q;
   assign code = code_q;
   assign done = done_q;
   a_sar_bit_count: assert property (@(posedge clk) disable iff (rst)
      start |=> mask_q == (W'(1) << acs_pkg::acs_res_msb($past(res))))
      else $error("search does not open at the top bit");
endmodule : acs_sar

// ==== src/acs_top.sv ====
// command list sequencer with APB registers, list fetch and conversion phases
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - sample via buffer two converter cycles, then directly for remaining time
// - two converter cycle pump phase precedes every sample phase
// - input disconnected from storage node while holding for conversion
// - resolution selectable as 8, 10 or 12 bits per conversion
// - binary search decides one bit per step, top bit first
// - below low reference gives zeros, above high reference gives ones
// - a list holds at most 64 commands, index never beyond 64
// - trigger runs sequence commands until end of sequence or end of list
// - two-bit type field tells normal, end of sequence, end of list
// - a list may hold zero to 63 sequences, all handled
// - commands double buffered, executing one readable, next loaded behind
// - fetch address is base plus list offset plus index
// - buffer mode bit; double mode swaps lists by load ok and restart
// - list select shows active list, forced zero in single mode
// - base pointer any even address, lowest bit always zero
// - access outside RAM sets illegal access flag and error interrupt
// - base, offset, index read only while enabled; index hardware owned
// - offsets and indices count entries, a command entry is 32 bits
// - trigger bit clears when first conversion begins sampling
module acs_top #(
   parameter int CONV_DIV = 8,
   parameter logic [23:0] RAM_LO = 24'h00_1000,
   parameter logic [23:0] RAM_HI = 24'h00_FFFF
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // system memory read port
   output acs_pkg::acs_mreq_t MEM,
   input wire logic MEM_ACK,
   input wire logic [31:0] MEM_RDATA,
   // analogue sub-block
   output acs_pkg::acs_ana_t ANA,
   input wire logic COMP_IN,
   // error interrupt
   output logic ERR_IRQ
);
   //////////////////////////////////////////////////////////////////////////
   // state
   logic en_q, bmod_q, trigger_bit_q, restart_bit_q, load_ok_bit_q, ien_q, ia_q, sel_q;
   logic [23:1] cbp_q;
   logic [acs_pkg::OFF_W-1:0] off0_q, off1_q;
   logic [acs_pkg::IDX_W-1:0] idx_q;
   logic [31:0] act_q, nxt_q;
   logic nxt_vld_q, fetch_q;
   logic [acs_pkg::RES_W-1:0] res_q;
   logic [acs_pkg::SMP_W-1:0] cnt_q, cnt_d;
   acs_pkg::acs_state_t state_q, state_d;
   acs_pkg::acs_ana_t ana_q;
   logic comp_s1_q, comp_s2_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;
   logic fetch_go, sar_go;

   //////////////////////////////////////////////////////////////////////////
   // apb decode
   wire apb_acc = PSEL && PENABLE;
   wire apb_wr = apb_acc && PWRITE;
   wire hit_ctrl = PADDR == acs_pkg::OFS_CTRL;
   wire hit_stat = PADDR == acs_pkg::OFS_STAT;
   wire hit_cbp = PADDR == acs_pkg::OFS_CBP;
   wire hit_off0 = PADDR == acs_pkg::OFS_OFF0;
   wire hit_off1 = PADDR == acs_pkg::OFS_OFF1;
   wire hit_idx = PADDR == acs_pkg::OFS_IDX;
   wire hit_cmd = PADDR == acs_pkg::OFS_CMD;
   wire hit_res = PADDR == acs_pkg::OFS_RES;
   wire hit_any = hit_ctrl | hit_stat | hit_cbp | hit_off0 | hit_off1 | hit_idx | hit_cmd | hit_res;
   wire wr_ctrl = apb_wr && hit_ctrl;
   wire addr_wr_ok = apb_wr && !en_q;
   wire idle = state_q == acs_pkg::ST_IDLE;

   //////////////////////////////////////////////////////////////////////////
   // command fetch address and range check
   wire [acs_pkg::OFF_W-1:0] off_sel = sel_q ? off1_q : off0_q;
   wire [acs_pkg::ADDR_W-1:0] entry = acs_pkg::ADDR_W'(off_sel) + acs_pkg::ADDR_W'(idx_q);
   wire [acs_pkg::ADDR_W-1:0] fetch_addr = {cbp_q, 1'b0} + (entry << acs_pkg::ENTRY_SHIFT);
   wire illegal = (fetch_addr < RAM_LO) || (fetch_addr > RAM_HI - 24'h00_0003);
   wire fetch_done = fetch_q && (MEM_ACK || illegal);
   wire [31:0] fetch_word = illegal ? acs_pkg::CMD_RST : MEM_RDATA;

   //////////////////////////////////////////////////////////////////////////
   // command decode
   acs_pkg::acs_cmd_type_t act_typ, nxt_typ;
   assign act_typ = acs_pkg::acs_cmd_type(act_q);
   assign nxt_typ = acs_pkg::acs_cmd_type(nxt_q);
   wire act_eol = act_typ == acs_pkg::TYP_END_LIST;
   wire act_stop = act_eol || act_typ == acs_pkg::TYP_END_SEQ;
   wire [1:0] act_res = act_q[acs_pkg::CMD_RES_LSB +: 2];
   wire [acs_pkg::SMP_W-1:0] act_smp = act_q[acs_pkg::CMD_SMP_LSB +: acs_pkg::SMP_W];
   wire [acs_pkg::SMP_W-1:0] fin_len = (act_smp > acs_pkg::SMP_W'(acs_pkg::BUF_CYC + 1)) ?
      act_smp - acs_pkg::SMP_W'(acs_pkg::BUF_CYC) : acs_pkg::SMP_W'(1);
   wire start_ok = idle && en_q && trigger_bit_q && nxt_vld_q && !fetch_q && !restart_bit_q;
   wire restart_go = idle && en_q && restart_bit_q && !fetch_q;
   wire swap = restart_go && bmod_q && load_ok_bit_q;

   //////////////////////////////////////////////////////////////////////////
   // converter clock and search engine
   logic tick, sar_done;
   logic [acs_pkg::RES_W-1:0] sar_dac, sar_code;
   acs_div #(.DIV(CONV_DIV)) acs_div_i (
      .clk(SYS_CLK),
      .rst(RST),
      .tick(tick)
   );
   acs_sar #(.W(acs_pkg::RES_W)) acs_sar_i (
      .clk(SYS_CLK),
      .rst(RST),
      .step(tick && state_q == acs_pkg::ST_CONV),
      .start(sar_go),
      .res(act_res),
      .comp(comp_s2_q),
      .dac(sar_dac),
      .code(sar_code),
      .done(sar_done)
   );

   //////////////////////////////////////////////////////////////////////////
   // phase sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      fetch_go = restart_go;
      sar_go = 1'b0;
      case (state_q)
         acs_pkg::ST_IDLE: begin
            cnt_d = '0;
            if (start_ok) begin
               state_d = acs_pkg::ST_PUMP;
               fetch_go = nxt_typ != acs_pkg::TYP_END_LIST;
            end
         end
         acs_pkg::ST_PUMP: if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == acs_pkg::SMP_W'(acs_pkg::PUMP_CYC - 1)) begin
               state_d = acs_pkg::ST_SBUF;
               cnt_d = '0;
            end
         end
         acs_pkg::ST_SBUF: if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == acs_pkg::SMP_W'(acs_pkg::BUF_CYC - 1)) begin
               state_d = acs_pkg::ST_SFIN;
               cnt_d = '0;
            end
         end
         acs_pkg::ST_SFIN: if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == fin_len - 1'b1) begin
               state_d = acs_pkg::ST_CONV;
               sar_go = 1'b1;
            end
         end
         acs_pkg::ST_CONV: if (sar_done) state_d = acs_pkg::ST_NEXT;
         acs_pkg::ST_NEXT: begin
            cnt_d = '0;
            if (act_stop) begin
               state_d = acs_pkg::ST_IDLE;
               fetch_go = act_eol;
            end else if (nxt_vld_q && !fetch_q) begin
               state_d = acs_pkg::ST_PUMP;
               fetch_go = nxt_typ != acs_pkg::TYP_END_LIST;
            end
         end
         default: state_d = acs_pkg::ST_IDLE;
      endcase
      if (!en_q) begin
         state_d = acs_pkg::ST_IDLE;
         fetch_go = 1'b0;
      end
   end

   wire take_next = (idle && start_ok) || (state_q == acs_pkg::ST_NEXT && state_d == acs_pkg::ST_PUMP);
   wire to_top = restart_go || (state_q == acs_pkg::ST_NEXT && act_eol && en_q);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_q <= acs_pkg::ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // command double buffer and index
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         act_q <= acs_pkg::CMD_RST;
         nxt_q <= acs_pkg::CMD_RST;
         nxt_vld_q <= 1'b0;
         fetch_q <= 1'b0;
         idx_q <= '0;
      end else begin
         if (take_next) act_q <= nxt_q;
         if (fetch_done) nxt_q <= fetch_word;
         nxt_vld_q <= fetch_done || (nxt_vld_q && !take_next && en_q);
         fetch_q <= en_q && (fetch_go || (fetch_q && !fetch_done));
         if (to_top) idx_q <= '0;
         else if (fetch_done) idx_q <= idx_q + 1'b1;
         else if (addr_wr_ok && hit_idx) idx_q <= PWDATA[acs_pkg::IDX_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         en_q <= 1'b0;
         bmod_q <= 1'b0;
         ien_q <= 1'b0;
         cbp_q <= '0;
         off0_q <= '0;
         off1_q <= '0;
      end else begin
         if (wr_ctrl) begin
            en_q <= PWDATA[acs_pkg::CTL_EN];
            bmod_q <= PWDATA[acs_pkg::CTL_BMOD];
            ien_q <= PWDATA[acs_pkg::CTL_IEN];
         end
         if (addr_wr_ok && hit_cbp) cbp_q <= PWDATA[23:1];
         if (addr_wr_ok && hit_off0) off0_q <= PWDATA[acs_pkg::OFF_W-1:0];
         if (addr_wr_ok && hit_off1) off1_q <= PWDATA[acs_pkg::OFF_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // flow control bits, list select and error flag
   wire sw_trigger_bit = wr_ctrl && PWDATA[acs_pkg::CTL_TRIGGER_BIT] && en_q && idle;
   wire sw_restart_bit = wr_ctrl && PWDATA[acs_pkg::CTL_RESTART_BIT] && en_q && idle;
   wire sw_load_ok_bit = wr_ctrl && PWDATA[acs_pkg::CTL_LOAD_OK_BIT];
   wire ia_clr = apb_wr && hit_stat && PWDATA[acs_pkg::STA_IA];
   wire samp_start = state_q == acs_pkg::ST_PUMP && state_d == acs_pkg::ST_SBUF;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         trigger_bit_q <= 1'b0;
         restart_bit_q <= 1'b0;
         load_ok_bit_q <= 1'b0;
         sel_q <= 1'b0;
         ia_q <= 1'b0;
      end else begin
         if (samp_start || !en_q) trigger_bit_q <= 1'b0;
         else if (sw_trigger_bit) trigger_bit_q <= 1'b1;
         if (sw_restart_bit) restart_bit_q <= 1'b1;
         else if (restart_go || !en_q) restart_bit_q <= 1'b0;
         if (sw_load_ok_bit) load_ok_bit_q <= 1'b1;
         else if (swap) load_ok_bit_q <= 1'b0;
         if (!bmod_q) sel_q <= 1'b0;
         else if (swap) sel_q <= !sel_q;
         if (fetch_q && illegal) ia_q <= 1'b1;
         else if (ia_clr) ia_q <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // analogue control, comparator sync, result
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ana_q <= '0;
         comp_s1_q <= 1'b0;
         comp_s2_q <= 1'b0;
         res_q <= '0;
      end else begin
         ana_q.pump <= state_q == acs_pkg::ST_PUMP;
         ana_q.buf_conn <= state_q == acs_pkg::ST_SBUF;
         ana_q.dir_conn <= state_q == acs_pkg::ST_SFIN;
         ana_q.hold <= state_q == acs_pkg::ST_CONV;
         ana_q.dac <= sar_dac;
         comp_s1_q <= COMP_IN;
         comp_s2_q <= comp_s1_q;
         if (sar_done) res_q <= sar_code;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read data
   assign rd_mux =
      hit_ctrl ? {26'h0, ien_q, load_ok_bit_q, restart_bit_q, trigger_bit_q, bmod_q, en_q} :
      hit_stat ? {28'h0, nxt_vld_q, idle, ia_q, sel_q} :
      hit_cbp ? {8'h00, cbp_q, 1'b0} :
      hit_off0 ? {25'h0, off0_q} :
      hit_off1 ? {25'h0, off1_q} :
      hit_idx ? {26'h0, idx_q} :
      hit_cmd ? act_q :
      hit_res ? {20'h0, res_q} : acs_pkg::RD_ZERO;
   always_ff @(posedge SYS_CLK) begin
      if (RST) rdata_q <= '0;
      else if (PSEL && !PENABLE && !PWRITE) rdata_q <= rd_mux;
   end

   assign PRDATA = rdata_q;
   assign PREADY = 1'b1;
   assign PSLVERR = apb_acc && !hit_any;
   assign MEM.req = fetch_q;
   assign MEM.addr = fetch_addr;
   assign ANA = ana_q;
   assign ERR_IRQ = ia_q && ien_q;

   //////////////////////////////////////////////////////////////////////////
   // checks
   wire pump_tick = tick && state_q == acs_pkg::ST_PUMP;
   wire in_sbuf = state_q == acs_pkg::ST_SBUF;
   a_pump_two_ticks: assert property (@(posedge SYS_CLK) disable iff (RST)
      samp_start |-> $past(pump_tick, (acs_pkg::PUMP_CYC - 1) * CONV_DIV))
      else $error("pump phase length wrong");
   a_buf_two_ticks: assert property (@(posedge SYS_CLK) disable iff (RST)
      (in_sbuf && state_d == acs_pkg::ST_SFIN) |-> $past(in_sbuf, acs_pkg::BUF_CYC * CONV_DIV - 1) &&
      !$past(in_sbuf, acs_pkg::BUF_CYC * CONV_DIV))
      else $error("buffered sample length wrong");
   a_hold_open: assert property (@(posedge SYS_CLK) disable iff (RST)
      state_q == acs_pkg::ST_CONV |=> !ana_q.buf_conn && !ana_q.dir_conn)
      else $error("input connected during hold");
   a_trigger_bit_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
      samp_start |=> !trigger_bit_q && state_q == acs_pkg::ST_SBUF)
      else $error("trigger not cleared at sample start");
   a_idx_advance: assert property (@(posedge SYS_CLK) disable iff (RST)
      fetch_done && !to_top |=> idx_q == $past(idx_q) + 1'b1)
      else $error("index did not advance");
   a_sel_single: assert property (@(posedge SYS_CLK) disable iff (RST)
      !bmod_q ##1 !bmod_q |-> !sel_q)
      else $error("list select set in single mode");
   a_ia_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
      fetch_q && illegal && ien_q |=> ia_q && ERR_IRQ)
      else $error("illegal access not flagged");
   a_ro_enabled: assert property (@(posedge SYS_CLK) disable iff (RST)
      en_q && apb_wr && hit_cbp |=> $stable(cbp_q))
      else $error("base pointer written while enabled");
   a_eol_top: assert property (@(posedge SYS_CLK) disable iff (RST)
      state_q == acs_pkg::ST_NEXT && act_eol && en_q |=> idle && idx_q == '0)
      else $error("end of list did not return to top");
endmodule : acs_top

// ==== dv/acs_mem_model.sv ====
// partner model: system memory read port and comparator
`timescale 1ns/1ps
module acs_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // memory read port
   input wire acs_pkg::acs_mreq_t mem,
   output logic ack,
   output logic [31:0] rdata,
   // analogue side
   input wire acs_pkg::acs_ana_t ana,
   input wire logic [11:0] level,
   input wire logic [3:0] lat,
   output logic comp
);
   logic [31:0] word_q [0:255];
   logic [3:0] wait_q;
   logic [23:0] last_addr;
   int fetch_cnt;
   // only system ram answers
   wire in_ram = mem.addr >= 24'h00_1000 && mem.addr <= 24'h00_FFFF;
   // input sits half a step above level
   assign comp = {level, 1'b1} > {ana.dac, 1'b0};
   always_ff @(posedge clk) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (rst) begin
         wait_q <= 4'h0;
         fetch_cnt <= 0;
         last_addr <= 24'h00_0000;
         rdata <= 32'hA5A5_A5A5;
      end else if (mem.req && !ack && in_ram) begin
         if (wait_q == lat) begin
            ack <= 1'b1;
            rdata <= word_q[mem.addr[9:2]];
            last_addr <= mem.addr;
            fetch_cnt <= fetch_cnt + 1;
            wait_q <= 4'h0;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end else if (!mem.req) begin
         wait_q <= 4'h0;
      end
   end
endmodule : acs_mem_model

// ==== dv/adc_command_list_sequencer_bench.sv ====
// testbench: register access, list fetch and conversion sequences
`timescale 1ns/1ps
module adc_command_list_sequencer_bench;
   localparam int DIV = 4;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, mrdata, rdv;
   logic pready, pslverr, mack, comp, irq, rde;
   logic [11:0] level = 12'h000;
   logic [3:0] lat = 4'h0;
   acs_pkg::acs_mreq_t mreq;
   acs_pkg::acs_ana_t ana;
   int err_count = 0, checks_done = 0, pump_n = 0, buf_n = 0, dir_n = 0;
   int pump_len = 0, buf_len = 0, dir_len = 0, conv_cnt = 0, hold_bad = 0;
   always #2.5 clk = ~clk;
   acs_top #(.CONV_DIV(DIV)) acs_top_i (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MEM(mreq), .MEM_ACK(mack), .MEM_RDATA(mrdata), .ANA(ana), .COMP_IN(comp), .ERR_IRQ(irq));
   acs_mem_model acs_mem_model_i (.clk(clk), .rst(rst), .mem(mreq), .ack(mack), .rdata(mrdata), .ana(ana),
      .level(level), .lat(lat), .comp(comp));
   ////////////////////////////////////////////////////////////////////////////
   // phase length monitor
   always @(posedge clk) begin
      if (!rst) begin
         pump_n <= ana.pump ? pump_n + 1 : 0;
         buf_n <= ana.buf_conn ? buf_n + 1 : 0;
         dir_n <= ana.dir_conn ? dir_n + 1 : 0;
         if (!ana.pump && pump_n > 0) pump_len <= pump_n;
         if (!ana.buf_conn && buf_n > 0) buf_len <= buf_n;
         if (!ana.dir_conn && dir_n > 0) dir_len <= dir_n;
         if ($rose(ana.hold)) conv_cnt <= conv_cnt + 1;
         if (ana.hold && (ana.buf_conn || ana.dir_conn)) hold_bad <= hold_bad + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic fail(input string what);
      err_count++;
      $display("MISMATCH %s expected done seen timeout", what);
      finish_test();
   endtask : fail
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) fail("apb ready");
      rdv = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, e, rdv & m);
   endtask : rdc
   task automatic wait_stat(input logic [31:0] m, input logic [31:0] e);
      for (int n = 0; n < 300; n++) begin
         apb(1'b0, acs_pkg::OFS_STAT, 32'h0000_0000);
         if ((rdv & m) === e) return;
      end
      fail("status");
   endtask : wait_stat
   task automatic wait_addr(input logic [23:0] e);
      for (int n = 0; n < 600; n++) begin
         @(posedge clk);
         if (acs_mem_model_i.last_addr === e) begin
            repeat (2) @(posedge clk);
            return;
         end
      end
      fail("fetch");
   endtask : wait_addr
   task automatic run_seq(input int n);
      for (int i = 0; i < 3000 && conv_cnt != n; i++) @(posedge clk);
      if (conv_cnt != n) fail("sequence");
      wait_stat(32'h0000_0004, 32'h0000_0004);
      rdc("trigger clear", acs_pkg::OFS_CTRL, 32'h0000_0004, 32'h0000_0000);
   endtask : run_seq
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      acs_mem_model_i.word_q[2] = 32'h0000_0059;
      acs_mem_model_i.word_q[3] = 32'h0000_0050;
      acs_mem_model_i.word_q[4] = 32'h0000_0055;
      acs_mem_model_i.word_q[5] = 32'h0000_0052;
      acs_mem_model_i.word_q[16] = 32'h0000_005A;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdc("cmd reset", acs_pkg::OFS_CMD, 32'hFFFF_FFFF, acs_pkg::CMD_RST);
      rdc("idx reset", acs_pkg::OFS_IDX, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, rde});
      wr(acs_pkg::OFS_CBP, 32'h0000_1001);
      rdc("cbp even", acs_pkg::OFS_CBP, 32'hFFFF_FFFF, 32'h0000_1000);
      wr(acs_pkg::OFS_OFF0, 32'h0000_0002);
      wr(acs_pkg::OFS_OFF1, 32'h0000_0010);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0001);
      wr(acs_pkg::OFS_CBP, 32'h0000_2000);
      rdc("cbp locked", acs_pkg::OFS_CBP, 32'hFFFF_FFFF, 32'h0000_1000);
      wr(acs_pkg::OFS_IDX, 32'h0000_0005);
      rdc("idx locked", acs_pkg::OFS_IDX, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0009);
      wait_addr(24'h00_1008);
      rdc("idx step", acs_pkg::OFS_IDX, 32'hFFFF_FFFF, 32'h0000_0001);
      level <= 12'h5A3;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0005);
      run_seq(1);
      rdc("res 12 bit", acs_pkg::OFS_RES, 32'hFFFF_FFFF, 32'h0000_05A3);
      rdc("cmd active", acs_pkg::OFS_CMD, 32'hFFFF_FFFF, 32'h0000_0059);
      chk("buffer len", 2 * DIV, buf_len);
      chk("direct len", 3 * DIV, dir_len);
      chk("pump len", 32'h0000_0001, {31'h0, pump_len > DIV && pump_len <= 2 * DIV});
      level <= 12'hFFF;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0005);
      run_seq(3);
      rdc("res 10 bit rail", acs_pkg::OFS_RES, 32'hFFFF_FFFF, 32'h0000_03FF);
      rdc("cmd end seq", acs_pkg::OFS_CMD, 32'hFFFF_FFFF, 32'h0000_0055);
      level <= 12'h000;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0005);
      run_seq(4);
      rdc("res 8 bit zero", acs_pkg::OFS_RES, 32'hFFFF_FFFF, 32'h0000_0000);
      wait_addr(24'h00_1008);
      rdc("idx top", acs_pkg::OFS_IDX, 32'hFFFF_FFFF, 32'h0000_0001);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0000);
      lat <= 4'h3;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0013);
      wr(acs_pkg::OFS_CTRL, 32'h0000_001B);
      wait_addr(24'h00_1040);
      rdc("select double", acs_pkg::OFS_STAT, 32'h0000_0001, 32'h0000_0001);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0000);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0011);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0019);
      wait_addr(24'h00_1008);
      rdc("select single", acs_pkg::OFS_STAT, 32'h0000_0001, 32'h0000_0000);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0000);
      wr(acs_pkg::OFS_CBP, 32'h0000_0100);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0021);
      wr(acs_pkg::OFS_CTRL, 32'h0000_0029);
      wait_stat(32'h0000_0002, 32'h0000_0002);
      chk("irq set", 32'h0000_0001, {31'h0, irq});
      wr(acs_pkg::OFS_STAT, 32'h0000_0002);
      rdc("flag clear", acs_pkg::OFS_STAT, 32'h0000_0002, 32'h0000_0000);
      chk("irq clear", 32'h0000_0000, {31'h0, irq});
      chk("hold isolated", 32'h0000_0000, hold_bad);
      chk("fetch count", 32'h0000_0007, acs_mem_model_i.fetch_cnt);
      finish_test();
   end
endmodule : adc_command_list_sequencer_bench
